// ==== mpr_host_model.sv ====
// Host model: SPI master making serial clock, chip select and control requests.
// Assumes the bank takes a request on rising i_sclk and answers one edge later.
`timescale 1ns/100ps
module mpr_host_model (
  // Answer from the bank
  input  wire logic             i_hit,
  input  wire logic [31:0]      i_rdata,
  // SPI link
  output logic                  o_sclk,
  output logic                  o_cs_n,
  output mpr_pkg::mpr_ctl_req_t o_req
);
  // ========================================
  // Control transactions
  // ========================================
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_req  = '0;
  end
  // Clock runs only inside a frame
  task automatic edges(input int n);
    repeat (n) begin
      #15 o_sclk = 1'b1;
      #15 o_sclk = 1'b0;
    end
  endtask
  // Lead-in edges let the soft reset state cross before it is read
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic hit);
    o_cs_n = 1'b0;
    o_req  = {1'b0, ~o_req[52:0]};
    edges(2);
    o_req  = {1'b1, w, mpr_pkg::MMS_STANDARD, a, d};
    // Reads are taken twice in a row from the same address
    if (!w) edges(1);
    #15 o_sclk = 1'b1;
    o_req <= {1'b0, ~o_req[52:0]};
    #15 o_sclk = 1'b0;
    // Hit drops on the next rising serial clock edge, so take the answer now
    rd  = i_rdata;
    hit = i_hit;
    edges(4);
  endtask
  task automatic cs_release();
    #15 o_cs_n = 1'b1;
  endtask
endmodule

// ==== mpr_id_cap_reset.sv ====
// Identification, capability and soft-reset register bank of the MAC-PHY.
// Assumes the SPI framing logic hands over decoded control accesses on the
// serial clock and keeps that clock running to the end of each access.
//
// Functional notes
// - The identification word carries the 22 upper OUI bits, bit reversed, in bits 31:10.
// - Bit 31 holds OUI bit 2 and bit 10 holds OUI bit 23; OUI bits 1:0 are not stored.
// - Transmit checksum checking acts only when the MAC does not append the FCS; cap bit 10.
// - In store-and-forward a frame with a bad checksum is never sent to the line.
// - In cut-through a frame with a bad checksum is aborted while on the line.
// - PHY registers are reached directly; cap bit 8 reads one and bit 9 reads zero.
// - Cap bit 7 reads one because cut-through is supported.
// - Auto-increment can be disabled for repeated access; cap bit 5 reads one.
// - Cap bits 2:0 read the code for an 8-byte minimum chunk payload.
// - Cap bits 9, 6 and 4 read zero as those features are absent.
// - Writing one to reset bit 0 resets MAC and PHY, and the bit then clears itself.
// - A requested soft reset waits until chip select is released.
// - With validation enabled and no MAC-appended FCS, the last 4 octets of each host frame are checked as FCS.
`timescale 1ns/100ps
module mpr_id_cap_reset #(
  parameter logic [23:0] OUI_VALUE   = 24'h5A3C96,  // Arbitrary value
  parameter logic [5:0]  MODEL_VALUE = 6'h2C,       // Arbitrary value
  parameter logic [3:0]  REV_VALUE   = 4'h7,        // Arbitrary value
  parameter int          RST_CYCLES  = mpr_pkg::SOFT_RST_CYCLES
) (
  // System clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  // SPI link: serial clock, chip select pin and decoded control access
  input  wire logic                      i_sclk,
  input  wire logic                      i_cs_n,
  input  wire mpr_pkg::mpr_ctl_req_t     i_ctl_req,
  output logic [31:0]                    o_ctl_rdata,
  output logic                           o_ctl_hit,
  // Transmit frame path
  input  wire mpr_pkg::mpr_tx_byte_t     i_tx_byte,
  input  wire mpr_pkg::mpr_tx_cfg_t      i_tx_cfg,
  output mpr_pkg::mpr_tx_verdict_t       o_tx_verdict,
  // Soft reset toward MAC and PHY
  output logic                           o_mac_phy_reset
);

  localparam int CNT_W = $clog2(RST_CYCLES + 1);

  // ==========================================================================
  // Register word builders
  // ==========================================================================
  function automatic logic [31:0] id_word(input logic [23:0] oui);
    logic [31:0] w;
    w = 32'h00000000;
    for (int k = 0; k < mpr_pkg::ID_OUI_BITS; k++) begin
      // Highest register bit takes the lowest stored OUI bit
      w[31 - k] = oui[mpr_pkg::ID_OUI_FIRST + k];
    end
    w[mpr_pkg::ID_MODEL_LSB +: 6] = MODEL_VALUE;
    w[3:0]                        = REV_VALUE;
    return w;
  endfunction

  function automatic logic [31:0] cap_word();
    logic [31:0] w;
    w = 32'h00000000;
    w[mpr_pkg::CAP_TX_CHECKSUM_VERIFY_BIT] = 1'b1;
    w[mpr_pkg::CAP_INDIRECT_PHY_BIT]       = 1'b0;
    w[mpr_pkg::CAP_DIRECT_PHY_BIT]         = 1'b1;
    w[mpr_pkg::CAP_CUT_THROUGH_BIT]        = 1'b1;
    w[mpr_pkg::CAP_FRAME_TIMESTAMP_BIT]    = 1'b0;
    w[mpr_pkg::CAP_ADDR_INC_DISABLE_BIT]   = 1'b1;
    w[mpr_pkg::CAP_CHUNK_SEQ_RETRY_BIT]    = 1'b0;
    w[2:0]                                 = mpr_pkg::CAP_MIN_CHUNK_8BYTE;
    return w;
  endfunction

  function automatic logic [31:0] rst_word(input logic busy);
    logic [31:0] w;
    w = mpr_pkg::SOFT_RST_RESET;
    w[mpr_pkg::SOFT_RST_BIT] = busy;
    return w;
  endfunction

  // ==========================================================================
  // Serial clock domain: register access
  // ==========================================================================
  // Repeated access to one address needs no extra state here; the framing
  // logic simply presents the same address again.
  logic [31:0] rdata_ff,    nxt_rdata;
  logic        hit_ff,      nxt_hit;
  logic        rst_tog_ff,  nxt_rst_tog;
  // Sequencer busy flag, declared here because this domain samples it
  logic        busy_ff,     nxt_busy;
  logic        busy_meta_ff;
  logic        busy_sync_ff;
  logic        std_sel;

  assign std_sel = i_ctl_req.valid &&
                   (i_ctl_req.memory_map_selector == mpr_pkg::MMS_STANDARD);

  always_comb begin
    nxt_rdata   = rdata_ff;
    nxt_hit     = 1'b0;
    nxt_rst_tog = rst_tog_ff;
    if (std_sel) begin
      nxt_hit = 1'b1;
      case (i_ctl_req.addr)
        mpr_pkg::ADDR_PHY_IDENTIFICATION: begin
          // Writes to read-only words are dropped
          if (!i_ctl_req.write) begin
            nxt_rdata = id_word(OUI_VALUE);
          end
        end
        mpr_pkg::ADDR_SPI_CAP: begin
          if (!i_ctl_req.write) begin
            nxt_rdata = cap_word();
          end
        end
        mpr_pkg::ADDR_SOFT_RST: begin
          if (i_ctl_req.write) begin
            // Only bit 0 is looked at; a toggle carries the request across
            if (i_ctl_req.wdata[mpr_pkg::SOFT_RST_BIT]) begin
              nxt_rst_tog = ~rst_tog_ff;
            end
          end else begin
            nxt_rdata = rst_word(busy_sync_ff);
          end
        end
        default: begin
          nxt_hit = 1'b0;
          if (!i_ctl_req.write) begin
            nxt_rdata = 32'h00000000;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff     <= 32'h00000000;
      hit_ff       <= 1'b0;
      rst_tog_ff   <= 1'b0;
      busy_meta_ff <= 1'b0;
      busy_sync_ff <= 1'b0;
    end else begin
      rdata_ff     <= nxt_rdata;
      hit_ff       <= nxt_hit;
      rst_tog_ff   <= nxt_rst_tog;
      busy_meta_ff <= busy_ff;
      busy_sync_ff <= busy_meta_ff;
    end
  end

  assign o_ctl_rdata = rdata_ff;
  assign o_ctl_hit   = hit_ff;

  // ==========================================================================
  // System clock domain: synchronisers
  // ==========================================================================
  logic cs_meta_ff;
  logic cs_sync_ff;
  logic cs_prev_ff;
  logic tog_meta_ff;
  logic tog_sync_ff;
  logic tog_prev_ff;
  logic cs_release;
  logic req_evt;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // Idle level of the pin, so no false release follows reset
      cs_meta_ff  <= 1'b1;
      cs_sync_ff  <= 1'b1;
      cs_prev_ff  <= 1'b1;
      tog_meta_ff <= 1'b0;
      tog_sync_ff <= 1'b0;
      tog_prev_ff <= 1'b0;
    end else begin
      cs_meta_ff  <= i_cs_n;
      cs_sync_ff  <= cs_meta_ff;
      cs_prev_ff  <= cs_sync_ff;
      tog_meta_ff <= rst_tog_ff;
      tog_sync_ff <= tog_meta_ff;
      tog_prev_ff <= tog_sync_ff;
    end
  end

  assign cs_release = cs_sync_ff && !cs_prev_ff;
  assign req_evt    = tog_sync_ff ^ tog_prev_ff;

  // ==========================================================================
  // System clock domain: soft reset sequencer
  // ==========================================================================
  // The request toggle always lands no later than the chip select release,
  // since the write completes on a serial clock edge before select rises.
  mpr_pkg::mpr_rst_state_t state_ff, nxt_state;
  logic [CNT_W-1:0]        cnt_ff,   nxt_cnt;
  logic                    rst_ff,   nxt_rst;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      mpr_pkg::RST_IDLE: begin
        nxt_cnt = '0;
        if (req_evt) begin
          nxt_state = cs_release ? mpr_pkg::RST_ACTIVE : mpr_pkg::RST_ARMED;
        end
      end
      mpr_pkg::RST_ARMED: begin
        if (cs_release) begin
          nxt_state = mpr_pkg::RST_ACTIVE;
          nxt_cnt   = '0;
        end
      end
      mpr_pkg::RST_ACTIVE: begin
        // Requests arriving mid-reset are absorbed by the reset itself
        if (cnt_ff == CNT_W'(RST_CYCLES - 1)) begin
          nxt_state = mpr_pkg::RST_IDLE;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      default: begin
        nxt_state = mpr_pkg::RST_IDLE;
        nxt_cnt   = '0;
      end
    endcase
    nxt_rst  = (nxt_state == mpr_pkg::RST_ACTIVE);
    nxt_busy = (nxt_state != mpr_pkg::RST_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= mpr_pkg::RST_IDLE;
      cnt_ff   <= '0;
      rst_ff   <= 1'b0;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      rst_ff   <= nxt_rst;
      busy_ff  <= nxt_busy;
    end
  end

  assign o_mac_phy_reset = rst_ff;

  // ==========================================================================
  // Transmit checksum checker, cleared by the soft reset
  // ==========================================================================
  mpr_tx_fcs_check u_fcs_check (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_clear   (rst_ff),
    .i_byte    (i_tx_byte),
    .i_cfg     (i_tx_cfg),
    .o_verdict (o_tx_verdict)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [31:0] rst_hi_cnt;
  logic        rd_id;
  logic        rd_cap;
  logic        rd_rst;
  logic        rd_miss;
  logic        wr_any;

  assign rd_id  = std_sel && !i_ctl_req.write && (i_ctl_req.addr == mpr_pkg::ADDR_PHY_IDENTIFICATION);
  assign rd_cap = std_sel && !i_ctl_req.write && (i_ctl_req.addr == mpr_pkg::ADDR_SPI_CAP);
  assign rd_rst = std_sel && !i_ctl_req.write && (i_ctl_req.addr == mpr_pkg::ADDR_SOFT_RST);
  assign rd_miss = std_sel && !i_ctl_req.write && (i_ctl_req.addr != mpr_pkg::ADDR_PHY_IDENTIFICATION) &&
                   (i_ctl_req.addr != mpr_pkg::ADDR_SPI_CAP) &&
                   (i_ctl_req.addr != mpr_pkg::ADDR_SOFT_RST);
  assign wr_any  = std_sel && i_ctl_req.write;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_hi_cnt <= 32'h00000000;
    end else begin
      rst_hi_cnt <= rst_ff ? rst_hi_cnt + 32'h00000001 : 32'h00000000;
    end
  end

  oui_order_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_id |=> o_ctl_rdata[31:22] == {OUI_VALUE[2], OUI_VALUE[3], OUI_VALUE[4],
      OUI_VALUE[5], OUI_VALUE[6], OUI_VALUE[7], OUI_VALUE[8], OUI_VALUE[9],
      OUI_VALUE[10], OUI_VALUE[11]})
    else $error("identifier bits out of order");
  oui_ends_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_id |=> o_ctl_rdata[31] == OUI_VALUE[mpr_pkg::ID_OUI_FIRST] &&
              o_ctl_rdata[mpr_pkg::ID_OUI_LSB] == OUI_VALUE[mpr_pkg::ID_OUI_LAST] && o_ctl_hit)
    else $error("identifier end bits wrong");
  id_model_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_id |=> o_ctl_rdata[9:4] == MODEL_VALUE && o_ctl_rdata[3:0] == REV_VALUE)
    else $error("model or revision wrong");
  cap_word_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_cap |=> o_ctl_rdata == mpr_pkg::SPI_CAP_RESET)
    else $error("capability word wrong");
  cap_direct_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_cap |=> o_ctl_rdata[8] && !o_ctl_rdata[9])
    else $error("direct access capability wrong");
  cap_cut_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_cap |=> o_ctl_rdata[7] && o_ctl_hit)
    else $error("cut through capability missing");
  cap_aid_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_cap ##1 rd_cap |=> o_ctl_rdata[5] && o_ctl_rdata == $past(o_ctl_rdata))
    else $error("repeated capability read differs");
  cap_min_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_cap |=> o_ctl_rdata[2:0] == 3'h3)
    else $error("minimum chunk size code wrong");
  cap_absent_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_cap |=> !o_ctl_rdata[9] && !o_ctl_rdata[6] && !o_ctl_rdata[4])
    else $error("absent feature reported");
  rst_resv_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_rst |=> o_ctl_rdata[31:1] == 31'h00000000)
    else $error("reserved reset bits not zero");
  miss_zero_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_miss |=> !o_ctl_hit && o_ctl_rdata == 32'h00000000)
    else $error("unmapped read not zero");
  write_keep_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    wr_any |=> $stable(o_ctl_rdata))
    else $error("write changed read data");
  cap_resv_a: assert property (@(posedge i_sclk) disable iff (!i_resetn)
    rd_cap |=> o_ctl_rdata[31:11] == 21'h000000 && !o_ctl_rdata[3])
    else $error("reserved capability bits set");
  rst_wait_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(o_mac_phy_reset) |-> $past(cs_release) && $past(cs_sync_ff))
    else $error("soft reset began before chip select release");
  rst_len_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(o_mac_phy_reset) |-> rst_hi_cnt == RST_CYCLES)
    else $error("soft reset pulse length wrong");
  rst_start_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (cs_release && ((req_evt && state_ff == mpr_pkg::RST_IDLE) ||
                    state_ff == mpr_pkg::RST_ARMED))
      |=> o_mac_phy_reset ##1 busy_ff)
    else $error("soft reset request lost");

  rst_done_cov: cover property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(o_mac_phy_reset));
  armed_cov: cover property (@(posedge i_clk) disable iff (!i_resetn)
    state_ff == mpr_pkg::RST_ARMED ##1 state_ff == mpr_pkg::RST_ARMED);
  id_read_cov: cover property (@(posedge i_sclk) disable iff (!i_resetn) rd_id ##1 rd_id);

endmodule

// ==== mpr_pkg.sv ====
// Shared constants, field layouts and carrier types for the identification,
// capability and soft-reset register bank of the single-pair MAC-PHY.
// Assumes the SPI framing logic decodes control transactions before this bank.
package mpr_pkg;

  // ==========================================================================
  // Register map (memory map selector 0)
  // ==========================================================================
  localparam logic [3:0]  MMS_STANDARD  = 4'h0;
  localparam logic [15:0] ADDR_PHY_IDENTIFICATION   = 16'h0001;
  localparam logic [15:0] ADDR_SPI_CAP  = 16'h0002;
  localparam logic [15:0] ADDR_SOFT_RST = 16'h0003;

  // ==========================================================================
  // Identification register layout
  // ==========================================================================
  localparam int ID_OUI_BITS  = 22;
  localparam int ID_OUI_FIRST = 2;
  localparam int ID_OUI_LAST  = 23;
  localparam int ID_OUI_LSB   = 10;
  localparam int ID_MODEL_LSB = 4;

  // ==========================================================================
  // Capability register layout
  // ==========================================================================
  localparam int CAP_TX_CHECKSUM_VERIFY_BIT = 10;
  localparam int CAP_INDIRECT_PHY_BIT       = 9;
  localparam int CAP_DIRECT_PHY_BIT         = 8;
  localparam int CAP_CUT_THROUGH_BIT        = 7;
  localparam int CAP_FRAME_TIMESTAMP_BIT    = 6;
  localparam int CAP_ADDR_INC_DISABLE_BIT   = 5;
  localparam int CAP_CHUNK_SEQ_RETRY_BIT    = 4;
  localparam logic [2:0]  CAP_MIN_CHUNK_8BYTE = 3'h3;
  localparam logic [31:0] SPI_CAP_RESET       = 32'h000005A3;

  // ==========================================================================
  // Soft reset register
  // ==========================================================================
  localparam int          SOFT_RST_BIT   = 0;
  localparam logic [31:0] SOFT_RST_RESET = 32'h00000000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS   = 25;
  localparam int SOFT_RST_NS     = 1000;
  localparam int SOFT_RST_CYCLES = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Frame check sequence
  // ==========================================================================
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  localparam logic [2:0]  FCS_OCTETS  = 3'h4;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    RST_IDLE   = 3'b001,
    RST_ARMED  = 3'b010,
    RST_ACTIVE = 3'b100
  } mpr_rst_state_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  memory_map_selector;
    logic [15:0] addr;
    logic [31:0] wdata;
  } mpr_ctl_req_t;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic [7:0] data;
  } mpr_tx_byte_t;

  typedef struct packed {
    logic tx_checksum_validate_enable;
    logic mac_appends_fcs;
    logic cut_through;
  } mpr_tx_cfg_t;

  typedef struct packed {
    logic forward;
    logic drop;
    logic abort;
    logic checksum_error;
  } mpr_tx_verdict_t;

  // Reflected CRC-32 update over one octet, LSB first
  function automatic logic [31:0] mpr_crc_byte(input logic [31:0] crc,
                                               input logic [7:0]  data);
    logic [31:0] c;
    c = crc ^ {24'h000000, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// ==== mpr_tx_fcs_check.sv ====
// Transmit checksum checker: runs a CRC over each host frame and gives a
// one-cycle verdict on the clock cycle after its last octet.
// Assumes octets arrive on i_clk with start and end marks from the SPI path.
`timescale 1ns/100ps
module mpr_tx_fcs_check (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_resetn,
  input  wire logic                     i_clear,
  // Frame octets and configuration
  input  wire mpr_pkg::mpr_tx_byte_t    i_byte,
  input  wire mpr_pkg::mpr_tx_cfg_t     i_cfg,
  // Verdict
  output mpr_pkg::mpr_tx_verdict_t      o_verdict
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [31:0]               crc_ff,     nxt_crc;
  logic [2:0]                len_ff,     nxt_len;
  logic                      verify_ff,  nxt_verify;
  logic                      ct_ff,      nxt_ct;
  mpr_pkg::mpr_tx_verdict_t  verdict_ff, nxt_verdict;

  logic [31:0] crc_in;
  logic [2:0]  len_in;
  logic        verify_now;
  logic        ct_now;
  logic        good;

  always_comb begin
    crc_in      = i_byte.sof ? mpr_pkg::CRC_INIT : crc_ff;
    len_in      = i_byte.sof ? 3'h0 : len_ff;
    // Checking only makes sense when the MAC is not appending its own FCS
    verify_now  = i_byte.sof ? (i_cfg.tx_checksum_validate_enable &&
                                !i_cfg.mac_appends_fcs) : verify_ff;
    ct_now      = i_byte.sof ? i_cfg.cut_through : ct_ff;
    nxt_crc     = crc_ff;
    nxt_len     = len_ff;
    nxt_verify  = verify_ff;
    nxt_ct      = ct_ff;
    nxt_verdict = '0;
    good        = 1'b0;
    if (i_byte.valid) begin
      // Running over data plus trailing FCS leaves the fixed residue
      nxt_crc    = mpr_pkg::mpr_crc_byte(crc_in, i_byte.data);
      nxt_len    = (len_in == 3'h7) ? len_in : len_in + 3'h1;
      nxt_verify = verify_now;
      nxt_ct     = ct_now;
      good       = (nxt_crc == mpr_pkg::CRC_RESIDUE) && (nxt_len > mpr_pkg::FCS_OCTETS);
      if (i_byte.eof) begin
        if (!verify_now || good) begin
          nxt_verdict.forward = 1'b1;
        end else if (ct_now) begin
          nxt_verdict.abort          = 1'b1;
          nxt_verdict.checksum_error = 1'b1;
        end else begin
          nxt_verdict.drop           = 1'b1;
          nxt_verdict.checksum_error = 1'b1;
        end
      end
    end
    if (i_clear) begin
      nxt_verdict = '0;
      nxt_len     = 3'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      crc_ff     <= mpr_pkg::CRC_INIT;
      len_ff     <= 3'h0;
      verify_ff  <= 1'b0;
      ct_ff      <= 1'b0;
      verdict_ff <= '0;
    end else begin
      crc_ff     <= nxt_crc;
      len_ff     <= nxt_len;
      verify_ff  <= nxt_verify;
      ct_ff      <= nxt_ct;
      verdict_ff <= nxt_verdict;
    end
  end

  assign o_verdict = verdict_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic last_unchecked;
  logic last_checked;
  assign last_unchecked = i_byte.valid && i_byte.eof && !verify_now && !i_clear;
  assign last_checked   = i_byte.valid && i_byte.eof && verify_now;

  skip_check_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    last_unchecked |=> o_verdict.forward && !o_verdict.checksum_error)
    else $error("unchecked frame not forwarded");
  sf_drop_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_verdict.drop |-> !$past(ct_now) && !o_verdict.forward && o_verdict.checksum_error)
    else $error("bad frame dropped outside store and forward");
  ct_abort_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_verdict.abort |-> $past(ct_now) && !o_verdict.drop && !o_verdict.forward)
    else $error("abort outside cut through");
  err_cause_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_verdict.checksum_error |-> $past(last_checked))
    else $error("checksum error without validation");
  drop_cov: cover property (@(posedge i_clk) disable iff (!i_resetn) o_verdict.drop);
  abort_cov: cover property (@(posedge i_clk) disable iff (!i_resetn) o_verdict.abort);

endmodule

// ==== tb_top.sv ====
// Self-checking bench for the identification, capability and soft-reset bank.
// Assumes the host model drives the SPI link and the bench the frame path.
`timescale 1ns/100ps
module tb_top;
  // ========================================
  // Set-up
  // ========================================
  localparam logic [23:0] OUI = 24'hC3A51E; // Arbitrary value
  localparam logic [5:0]  MDL = 6'h15;      // Arbitrary value
  localparam logic [3:0]  RV  = 4'h9;       // Arbitrary value
  localparam int          RSN = 4;
  logic                     clk = 1'b0;
  logic                     resetn = 1'b0;
  logic                     sclk, cs_n, hit, mrst, h;
  logic [31:0]              rdata, rd;
  mpr_pkg::mpr_ctl_req_t    req;
  mpr_pkg::mpr_tx_byte_t    txb = '0;
  mpr_pkg::mpr_tx_cfg_t     cfg = '0;
  mpr_pkg::mpr_tx_verdict_t vd;
  int                       n_errors = 0;
  int                       n_checks = 0;
  always #12.5 clk = ~clk;
  mpr_host_model mpr_host_model_inst (.i_hit(hit), .i_rdata(rdata), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_req(req));
  mpr_id_cap_reset #(.OUI_VALUE(OUI), .MODEL_VALUE(MDL), .REV_VALUE(RV), .RST_CYCLES(RSN))
    mpr_id_cap_reset_inst (.i_clk(clk), .i_resetn(resetn), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_ctl_req(req), .o_ctl_rdata(rdata), .o_ctl_hit(hit), .i_tx_byte(txb),
    .i_tx_cfg(cfg), .o_tx_verdict(vd), .o_mac_phy_reset(mrst));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic eh);
    mpr_host_model_inst.xfer(w, a, d, rd, h);
    mpr_host_model_inst.cs_release();
    if (!w)
      check(rd, e);
    check({31'h0, h}, {31'h0, eh});
  endtask
  // ========================================
  // Scenarios
  // ========================================
  task automatic t_regs();
    logic [31:0] id;
    id = {22'h0, MDL, RV};
    for (int k = 0; k < 22; k++) id[31-k] = OUI[2+k];
    for (int i = 0; i < 2; i++) begin
      acc(1'b0, mpr_pkg::ADDR_PHY_IDENTIFICATION, 32'h0, id, 1'b1);
      acc(1'b0, mpr_pkg::ADDR_SPI_CAP, 32'h0, 32'h5A3, 1'b1);
      acc(1'b1, mpr_pkg::ADDR_PHY_IDENTIFICATION, 32'hFFFFFFFF, 32'h0, 1'b1);
      acc(1'b1, mpr_pkg::ADDR_SPI_CAP, 32'hFFFFFFFF, 32'h0, 1'b1);
    end
    acc(1'b1, mpr_pkg::ADDR_SOFT_RST, 32'hFFFFFFFE, 32'h0, 1'b1);
    acc(1'b0, mpr_pkg::ADDR_SOFT_RST, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 16'h0004, 32'h0, 32'h0, 1'b0);
    $display("test regs done");
  endtask
  task automatic t_reset();
    int n;
    mpr_host_model_inst.xfer(1'b1, mpr_pkg::ADDR_SOFT_RST, 32'h1, rd, h);
    repeat (8) @(posedge clk) #1;
    check({31'h0, mrst}, 32'h0);
    mpr_host_model_inst.xfer(1'b0, mpr_pkg::ADDR_SOFT_RST, 32'h0, rd, h);
    check(rd, 32'h1);
    mpr_host_model_inst.cs_release();
    for (n = 0; n < 20 && mrst !== 1'b1; n++) @(posedge clk) #1;
    for (n = 0; n < 60 && mrst === 1'b1; n++) @(posedge clk) #1;
    check(n, RSN);
    acc(1'b0, mpr_pkg::ADDR_SOFT_RST, 32'h0, 32'h0, 1'b1);
    $display("test reset done");
  endtask
  // Six payload octets, then the checksum low octet first; bad flips one bit
  task automatic t_frame(input logic [2:0] c, input logic bad, input logic [3:0] exp);
    logic [31:0] crc;
    logic [79:0] f;
    f[47:0] = 48'h0123456789AB;
    crc = 32'hFFFFFFFF;
    for (int i = 0; i < 48; i++)
      crc = (crc[0] ^ f[i]) ? ((crc >> 1) ^ mpr_pkg::CRC_POLY) : (crc >> 1);
    f[79:48] = ~crc ^ {31'h0, bad};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      cfg <= c;
      txb <= {1'b1, i == 0, i == 9, f[8*i +: 8]};
    end
    @(posedge clk);
    txb <= {3'b000, ~f[79:72]};
    #1 check({28'h0, vd}, {28'h0, exp});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_reset();
    t_frame(3'b100, 1'b0, 4'b1000);
    t_frame(3'b100, 1'b1, 4'b0101);
    t_frame(3'b101, 1'b1, 4'b0011);
    t_frame(3'b110, 1'b1, 4'b1000);
    $display("test frames done");
    finish_test();
  end
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule
